// file: hw/stf_pkg.sv
// stf_pkg: constants and types of the soft trap and frame entry unit.
// assumes: one clock, APB register access with 32-bit data.
package stf_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_OPA    = 8'h04;
  localparam logic [7:0] OFS_OPB    = 8'h08;
  localparam logic [7:0] OFS_FLAGS  = 8'h0c;
  localparam logic [7:0] OFS_IP     = 8'h10;
  localparam logic [7:0] OFS_CS     = 8'h14;
  localparam logic [7:0] OFS_SP     = 8'h18;
  localparam logic [7:0] OFS_FBP    = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_MADDR  = 8'h24;
  localparam logic [7:0] OFS_MDATA  = 8'h28;
  localparam logic [7:0] OFS_SEGQ   = 8'h2c;

  // ****************************************
  // command codes and field positions
  // ****************************************
  localparam logic [3:0] OP_SWINT = 4'h1;
  localparam logic [3:0] OP_INTO  = 4'h2;
  localparam logic [3:0] OP_INT3  = 4'h3;
  localparam logic [3:0] OP_BOUND = 4'h4;
  localparam logic [3:0] OP_FPEXC = 4'h5;
  localparam logic [3:0] OP_INTERRUPT_RETURN_INSTRUCTION  = 4'h6;
  localparam logic [3:0] OP_ENTER = 4'h7;
  localparam logic [3:0] OP_LEAVE = 4'h8;
  localparam int CMD_ERRC_BIT = 8;
  localparam int CMD_SIMD_BIT = 9;
  localparam int LEVEL_W      = 5;
  localparam int FP_COND_W    = 6;

  // ****************************************
  // vectors, flag bits, status bits
  // ****************************************
  localparam logic [7:0] VEC_BP = 8'h03;
  localparam logic [7:0] VEC_OF = 8'h04;
  localparam logic [7:0] VEC_BR = 8'h05;
  localparam logic [7:0] VEC_MF = 8'h10;
  localparam logic [7:0] VEC_XF = 8'h13;
  localparam int OF_BIT = 11;
  localparam int IF_BIT = 9;
  localparam int TF_BIT = 8;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_TRAP_BIT   = 1;
  localparam int ST_CMDERR_BIT = 2;
  localparam logic [2:0] BASE_SP  = 3'h4;
  localparam logic [2:0] BASE_FBP = 3'h5;

  // ****************************************
  // reset values and word step
  // ****************************************
  localparam logic [31:0] FLAGS_RST  = 32'h0000_0002;
  localparam logic [31:0] SP_RST     = 32'h0000_1000;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [13:0] {
    S_IDLE   = 14'h0001,
    S_DISP   = 14'h0002,
    S_PFL    = 14'h0004,
    S_PCS    = 14'h0008,
    S_PIP    = 14'h0010,
    S_PERR   = 14'h0020,
    S_VEC    = 14'h0040,
    S_POIP   = 14'h0080,
    S_POCS   = 14'h0100,
    S_POFL   = 14'h0200,
    S_ENSAVE = 14'h0400,
    S_ENCOPY = 14'h0800,
    S_ENLINK = 14'h1000,
    S_ENDONE = 14'h2000
  } stf_phase_t;

  typedef struct packed {
    stf_phase_t  st;
    logic [31:0] flags;
    logic [31:0] ip;
    logic [31:0] cs;
    logic [31:0] sp;
    logic [31:0] fbp;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] tmp;
    logic [31:0] maddr;
    logic [9:0]  cmd;
    logic [7:0]  vec;
    logic [4:0]  cnt;
    logic        trapped;
    logic        cmderr;
    logic [2:0]  segq;
    logic        busy;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } stf_state_t;

endpackage : stf_pkg

// file: hw/stf_unit.sv
// stf_unit: trap entry, interrupt return and frame entry/leave engine.
// assumes: APB master on pclk, memory image loaded through MADDR/MDATA.
// Notes on behaviour
// - trap vector indexes the table; handler pointer loaded as far call.
// - flags, code segment, instruction pointer, optional error code pushed first.
// - interrupt return pops instruction pointer, code segment, flags.
// - software interrupt takes any vector operand.
// - overflow trap fires only when overflow flag set, else no trap.
// - overflow exception never raised by arithmetic, only vector 4 paths.
// - breakpoint command always traps to vector 3.
// - bounds check compares operand to memory limits, traps when outside.
// - no implicit bounds checks; vector 5 only from check or software.
// - six fp conditions route to fpu error or simd exception.
// - frame entry takes storage byte count and level 0..31.
// - level sets how many frame pointers get copied from old display.
// - previous frame pointer is first doubleword of each display.
// - after display, stack pointer drops by storage count.
// - frame base pointer ends on display's first, highest doubleword.
// - frame base pointer as base selects stack segment.
// - level 0 pushes, links, subtracts storage, copies nothing.
// - level 1 pushes the new frame pointer, then allocates storage, no earlier display copied.
// - deeper call places caller frame pointer into new display.
// - same level call copies enclosing entries only, no caller pointer.
// - frame leave loads stack from frame base then pops it.
//
// Added by the designer: register access over APB and the register offsets.
module stf_unit
  import stf_pkg::*;
#(
  parameter int MEM_DEPTH = 1024
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // engine status
  output logic             busy
);

  localparam int IW = $clog2(MEM_DEPTH);

  // ****************************************
  // state and memory
  // ****************************************
  stf_state_t  state_reg;
  stf_state_t  state_next;
  logic [31:0] mem [MEM_DEPTH];
  logic          mem_we;
  logic [IW-1:0] mem_wi;
  logic [31:0]   mem_wd;

  // derived addresses and operands
  logic [31:0]   push_sp;
  logic [IW-1:0] push_idx;
  logic [31:0]   fbp_dn;
  logic [31:0]   word_sp;
  logic [31:0]   word_fbp;
  logic [31:0]   word_fbp_dn;
  logic [31:0]   word_vec;
  logic [31:0]   word_lo;
  logic [31:0]   word_hi;
  logic [31:0]   word_maddr;
  logic [31:0]   opb_hi;
  logic [4:0]    level;
  logic [3:0]    op;
  logic          out_of_range;
  logic          stack_sel;

  assign push_sp      = state_reg.sp - WORD_BYTES;
  assign push_idx     = push_sp[IW+1:2];
  assign fbp_dn       = state_reg.fbp - WORD_BYTES;
  assign opb_hi       = state_reg.opb + WORD_BYTES;
  assign word_sp      = mem[state_reg.sp[IW+1:2]];
  assign word_fbp     = mem[state_reg.fbp[IW+1:2]];
  assign word_fbp_dn  = mem[fbp_dn[IW+1:2]];
  assign word_vec     = mem[IW'(state_reg.vec)];
  assign word_lo      = mem[state_reg.opb[IW+1:2]];
  assign word_hi      = mem[opb_hi[IW+1:2]];
  assign word_maddr   = mem[state_reg.maddr[IW+1:2]];
  assign level        = state_reg.opb[LEVEL_W-1:0];
  assign op           = state_reg.cmd[3:0];
  // signed compare against both limits held in memory
  assign out_of_range = ($signed(state_reg.opa) < $signed(word_lo)) ||
                        ($signed(state_reg.opa) > $signed(word_hi));
  // base register selects stack segment
  assign stack_sel    = (state_reg.segq == BASE_FBP) || (state_reg.segq == BASE_SP);

  // ****************************************
  // apb decode
  // ****************************************
  logic        apb_first;
  logic        apb_wr;
  logic        mapped;
  logic        refuse;
  logic [31:0] rd_mux;

  assign apb_first = psel & penable & ~state_reg.pready;
  assign apb_wr    = psel & penable & state_reg.pready & pwrite & ~state_reg.pslverr;

  // read mux and address map
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = (paddr[31:8] == 24'h00_0000);
    unique case (paddr[7:0])
      OFS_CMD:    rd_mux = {22'h00_0000, state_reg.cmd};
      OFS_OPA:    rd_mux = state_reg.opa;
      OFS_OPB:    rd_mux = state_reg.opb;
      OFS_FLAGS:  rd_mux = state_reg.flags;
      OFS_IP:     rd_mux = state_reg.ip;
      OFS_CS:     rd_mux = state_reg.cs;
      OFS_SP:     rd_mux = state_reg.sp;
      OFS_FBP:    rd_mux = state_reg.fbp;
      OFS_STATUS: rd_mux = {16'h0000, state_reg.vec, 5'h00,
                            state_reg.cmderr, state_reg.trapped, state_reg.busy};
      OFS_MADDR:  rd_mux = state_reg.maddr;
      OFS_MDATA:  rd_mux = word_maddr;
      OFS_SEGQ:   rd_mux = {28'h000_0000, stack_sel, state_reg.segq};
      default:    mapped = 1'b0;
    endcase
    // writes other than status are refused while the engine runs
    refuse = ~mapped | (pwrite & state_reg.busy & (paddr[7:0] != OFS_STATUS));
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    mem_we     = 1'b0;
    mem_wi     = push_idx;
    mem_wd     = 32'h0000_0000;

    // bus answer: one wait cycle, data and error latched with it
    state_next.pready = apb_first;
    if (apb_first) begin
      state_next.prdata  = mapped ? rd_mux : 32'h0000_0000; // unmapped reads give zero
      state_next.pslverr = refuse;
    end

    // register writes; clears come first so a same-cycle set wins
    if (apb_wr) begin
      unique case (paddr[7:0])
        OFS_CMD: begin
          state_next.cmd = pwdata[9:0];
          state_next.st  = S_DISP;
        end
        OFS_OPA:   state_next.opa   = pwdata;
        OFS_OPB:   state_next.opb   = pwdata;
        OFS_FLAGS: state_next.flags = pwdata;
        OFS_IP:    state_next.ip    = pwdata;
        OFS_CS:    state_next.cs    = pwdata;
        OFS_SP:    state_next.sp    = pwdata;
        OFS_FBP:   state_next.fbp   = pwdata;
        OFS_STATUS: begin
          if (pwdata[ST_TRAP_BIT]) state_next.trapped = 1'b0;
          if (pwdata[ST_CMDERR_BIT]) state_next.cmderr = 1'b0;
        end
        OFS_MADDR: state_next.maddr = pwdata;
        OFS_MDATA: begin
          mem_we = 1'b1;
          mem_wi = state_reg.maddr[IW+1:2];
          mem_wd = pwdata;
        end
        OFS_SEGQ:  state_next.segq = pwdata[2:0];
        default: ;
      endcase
    end

    // engine
    unique case (state_reg.st)
      S_IDLE: ;
      S_DISP: begin
        state_next.st = S_IDLE;
        case (op)
          OP_SWINT: begin
            state_next.vec = state_reg.opa[7:0];
            state_next.st  = S_PFL;
          end
          OP_INTO: begin
            // only the flag is read; no arithmetic path raises this
            if (state_reg.flags[OF_BIT]) begin
              state_next.vec = VEC_OF;
              state_next.st  = S_PFL;
            end
          end
          OP_INT3: begin
            state_next.vec = VEC_BP;
            state_next.st  = S_PFL;
          end
          OP_BOUND: begin
            if (out_of_range) begin
              state_next.vec = VEC_BR;
              state_next.st  = S_PFL;
            end
          end
          OP_FPEXC: begin
            if (|state_reg.opa[FP_COND_W-1:0]) begin
              state_next.vec = state_reg.cmd[CMD_SIMD_BIT] ? VEC_XF : VEC_MF;
              state_next.st  = S_PFL;
            end
          end
          OP_INTERRUPT_RETURN_INSTRUCTION:  state_next.st = S_POIP;
          OP_ENTER: state_next.st = S_ENSAVE;
          OP_LEAVE: begin
            // stack from frame base, then pop the saved frame base
            state_next.sp  = state_reg.fbp + WORD_BYTES;
            state_next.fbp = word_fbp;
          end
          default: state_next.cmderr = 1'b1;
        endcase
      end
      // trap entry pushes: flags, code segment, ip, error code
      S_PFL: begin
        mem_we        = 1'b1;
        mem_wd        = state_reg.flags;
        state_next.sp = push_sp;
        state_next.st = S_PCS;
      end
      S_PCS: begin
        mem_we        = 1'b1;
        mem_wd        = state_reg.cs;
        state_next.sp = push_sp;
        state_next.st = S_PIP;
      end
      S_PIP: begin
        mem_we        = 1'b1;
        mem_wd        = state_reg.ip;
        state_next.sp = push_sp;
        state_next.st = state_reg.cmd[CMD_ERRC_BIT] ? S_PERR : S_VEC;
      end
      S_PERR: begin
        mem_we        = 1'b1;
        mem_wd        = state_reg.opb;
        state_next.sp = push_sp;
        state_next.st = S_VEC;
      end
      // far call through the table word: low half ip, high half segment
      S_VEC: begin
        state_next.ip              = {16'h0000, word_vec[15:0]};
        state_next.cs              = {16'h0000, word_vec[31:16]};
        state_next.flags[IF_BIT]   = 1'b0;
        state_next.flags[TF_BIT]   = 1'b0;
        state_next.trapped         = 1'b1;
        state_next.st              = S_IDLE;
      end
      // interrupt return pops in reverse order
      S_POIP: begin
        state_next.ip = word_sp;
        state_next.sp = state_reg.sp + WORD_BYTES;
        state_next.st = S_POCS;
      end
      S_POCS: begin
        state_next.cs = word_sp;
        state_next.sp = state_reg.sp + WORD_BYTES;
        state_next.st = S_POFL;
      end
      S_POFL: begin
        state_next.flags = word_sp;
        state_next.sp    = state_reg.sp + WORD_BYTES;
        state_next.st    = S_IDLE;
      end
      // frame entry: save old frame base, remember new frame top
      S_ENSAVE: begin
        mem_we         = 1'b1;
        mem_wd         = state_reg.fbp;
        state_next.sp  = push_sp;
        state_next.tmp = push_sp;
        if (level == 5'h00) begin
          state_next.st = S_ENDONE;
        end else if (level == 5'h01) begin
          state_next.st = S_ENLINK;
        end else begin
          state_next.cnt = level - 5'h01;
          state_next.st  = S_ENCOPY;
        end
      end
      // copy enclosing frame pointers from the old display
      S_ENCOPY: begin
        mem_we          = 1'b1;
        mem_wd          = word_fbp_dn;
        state_next.fbp  = fbp_dn;
        state_next.sp   = push_sp;
        state_next.cnt  = state_reg.cnt - 5'h01;
        if (state_reg.cnt == 5'h01) state_next.st = S_ENLINK;
      end
      // pointer to the new frame closes the display
      S_ENLINK: begin
        mem_we        = 1'b1;
        mem_wd        = state_reg.tmp;
        state_next.sp = push_sp;
        state_next.st = S_ENDONE;
      end
      S_ENDONE: begin
        state_next.fbp = state_reg.tmp;
        state_next.sp  = state_reg.sp - {16'h0000, state_reg.opa[15:0]};
        state_next.st  = S_IDLE;
      end
    endcase
    state_next.busy = (state_next.st != S_IDLE);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= '0;
      state_reg.st    <= S_IDLE;
      state_reg.flags <= FLAGS_RST;
      state_reg.sp    <= SP_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // memory write port, no reset
  always_ff @(posedge pclk) begin
    if (mem_we) mem[mem_wi] <= mem_wd;
  end

  assign pready  = state_reg.pready;
  assign prdata  = state_reg.prdata;
  assign pslverr = state_reg.pslverr;
  assign busy    = state_reg.busy;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic disp;
  assign disp = (state_reg.st == S_DISP);

  into_skip_a: assert property (disp && op == OP_INTO && !state_reg.flags[OF_BIT]
    |=> state_reg.st == S_IDLE && state_reg.vec == $past(state_reg.vec))
    else $error("overflow trap taken with flag clear");
  into_take_a: assert property (disp && op == OP_INTO && state_reg.flags[OF_BIT]
    && !state_reg.cmd[CMD_ERRC_BIT]
    |=> state_reg.vec == VEC_OF ##4 state_reg.trapped)
    else $error("overflow trap missed");
  brk_vector_a: assert property (disp && op == OP_INT3
    |=> state_reg.st == S_PFL && state_reg.vec == VEC_BP)
    else $error("breakpoint vector wrong");
  bound_check_a: assert property (disp && op == OP_BOUND
    |=> (state_reg.st == S_PFL) == $past(out_of_range))
    else $error("bounds decision wrong");
  push_order_a: assert property (state_reg.st == S_PFL
    |=> state_reg.st == S_PCS ##1 state_reg.st == S_PIP)
    else $error("push order broken");
  vector_load_a: assert property (state_reg.st == S_VEC
    |=> {state_reg.cs[15:0], state_reg.ip[15:0]} == $past(word_vec))
    else $error("handler pointer not loaded");
  interrupt_return_instruction_seq_a: assert property (disp && op == OP_INTERRUPT_RETURN_INSTRUCTION
    |=> state_reg.st == S_POIP ##3 state_reg.sp == $past(state_reg.sp, 3) + 32'h0000_000c)
    else $error("return sequence wrong");
  fp_route_a: assert property (disp && op == OP_FPEXC && (|state_reg.opa[5:0])
    |=> state_reg.vec == (state_reg.cmd[CMD_SIMD_BIT] ? VEC_XF : VEC_MF))
    else $error("fp exception misrouted");
  level_zero_a: assert property (state_reg.st == S_ENSAVE && level == 5'h00
    |=> state_reg.st == S_ENDONE ##1 state_reg.fbp == $past(state_reg.sp, 2) - 32'h4)
    else $error("level zero entry wrong");
  frame_top_a: assert property (state_reg.st == S_ENDONE
    |=> state_reg.sp == $past(state_reg.sp) - {16'h0000, $past(state_reg.opa[15:0])})
    else $error("storage not reserved");
  frame_leave_a: assert property (disp && op == OP_LEAVE
    |=> state_reg.sp == $past(state_reg.fbp) + 32'h4 && state_reg.fbp == $past(word_fbp))
    else $error("frame leave wrong");

  trap_taken_c: cover property (state_reg.st == S_VEC ##1 state_reg.trapped);
  nested_copy_c: cover property (state_reg.st == S_ENCOPY ##1 state_reg.st == S_ENCOPY);
  interrupt_return_instruction_done_c: cover property (state_reg.st == S_POFL ##1 state_reg.st == S_IDLE);

endmodule // stf_unit

// file: tb/stf_unit_tb.sv
// stf_unit_tb: self-checking bench for the trap and frame entry unit.
// assumes: stf_pkg compiled first; MDATA reads and writes the memory word at byte address MADDR.
module stf_unit_tb
  import stf_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // signals and clock
  // ****************************************
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  int          err_count;
  int          total_checks;

  // free running 10 mhz clock
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  stf_unit #(.MEM_DEPTH(1024)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .busy(busy));

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, {24'h0, o}, d, r, e);
  endtask

  task automatic rchk(input logic [7:0] o, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, {24'h0, o}, 32'h0, r, e);
    chk(r, x);
  endtask

  task automatic mw(input logic [31:0] a, input logic [31:0] d);
    wr(OFS_MADDR, a); wr(OFS_MDATA, d);
  endtask

  task automatic mchk(input logic [31:0] a, input logic [31:0] x);
    wr(OFS_MADDR, a); rchk(OFS_MDATA, x);
  endtask

  // wait for the engine to drop busy, bounded
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy === 1'b1 && n < 60);
    if (n >= 60) chk(32'h1, 32'h0);
  endtask

  task automatic go(input logic [31:0] c);
    wr(OFS_CMD, c); idle();
  endtask

  function automatic logic [31:0] cw(input logic [3:0] op, input logic e, input logic s);
    return {22'h0, s, e, 4'h0, op};
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  // loads state, runs one command, checks trap entry or no trap
  task automatic run_op(input logic [31:0] c, input logic [31:0] f, input logic [31:0] a,
                        input logic [31:0] b, input logic [7:0] v, input logic trap);
    logic [31:0] e;
    e = c[8] ? 32'h4 : 32'h0;
    mw({22'h0, v, 2'b00}, {8'h20, v, 8'h04, v});
    wr(OFS_FLAGS, f); wr(OFS_IP, 32'h1234); wr(OFS_CS, 32'h42); wr(OFS_SP, 32'h800);
    wr(OFS_OPA, a); wr(OFS_OPB, b); wr(OFS_STATUS, 32'h6);
    go(c);
    if (trap) begin
      rchk(OFS_STATUS, {16'h0, v, 8'h02});
      rchk(OFS_IP, {16'h0, 8'h04, v});
      rchk(OFS_CS, {16'h0, 8'h20, v});
      rchk(OFS_SP, 32'h7f4 - e);
      rchk(OFS_FLAGS, f & ~32'h300);
      mchk(32'h7fc, f);
      mchk(32'h7f8, 32'h42);
      mchk(32'h7f4, 32'h1234);
      if (c[8]) mchk(32'h7f0, b);
    end else begin
      rchk(OFS_IP, 32'h1234);
      rchk(OFS_SP, 32'h800);
    end
  endtask

  task automatic t_traps();
    mw(32'h200, 32'hffff_fffb);
    mw(32'h204, 32'h0000_000a);
    run_op(cw(OP_INT3, 1'b0, 1'b0), 32'h302, 32'h0, 32'h0, VEC_BP, 1'b1);
    run_op(cw(OP_SWINT, 1'b1, 1'b0), 32'h302, 32'h44, 32'he5, 8'h44, 1'b1);
    run_op(cw(OP_SWINT, 1'b0, 1'b0), 32'h302, 32'h4, 32'h0, VEC_OF, 1'b1);
    run_op(cw(OP_INTO, 1'b0, 1'b0), 32'h302, 32'h0, 32'h0, VEC_OF, 1'b0);
    run_op(cw(OP_INTO, 1'b0, 1'b0), 32'hb02, 32'h0, 32'h0, VEC_OF, 1'b1);
    run_op(cw(OP_BOUND, 1'b0, 1'b0), 32'h302, 32'ha, 32'h200, VEC_BR, 1'b0);
    run_op(cw(OP_BOUND, 1'b0, 1'b0), 32'h302, 32'hffff_fffa, 32'h200, VEC_BR, 1'b1);
    run_op(cw(OP_SWINT, 1'b0, 1'b0), 32'h302, 32'h5, 32'h0, VEC_BR, 1'b1);
    run_op(cw(OP_FPEXC, 1'b0, 1'b0), 32'h302, 32'h1, 32'h0, VEC_MF, 1'b1);
    run_op(cw(OP_FPEXC, 1'b0, 1'b1), 32'h302, 32'h20, 32'h0, VEC_XF, 1'b1);
    $display("test traps done");
  endtask

  task automatic t_interrupt_return_instruction();
    run_op(cw(OP_INT3, 1'b0, 1'b0), 32'hb02, 32'h0, 32'h0, VEC_BP, 1'b1);
    go(cw(OP_INTERRUPT_RETURN_INSTRUCTION, 1'b0, 1'b0));
    rchk(OFS_IP, 32'h1234);
    rchk(OFS_CS, 32'h42);
    rchk(OFS_FLAGS, 32'hb02);
    rchk(OFS_SP, 32'h800);
    $display("test interrupt_return_instruction done");
  endtask

  // write during a trap is refused; unmapped places answer with an error
  task automatic t_refuse();
    logic [31:0] r;
    logic        e;
    wr(OFS_OPA, 32'h11); wr(OFS_SP, 32'h800);
    wr(OFS_CMD, cw(OP_INT3, 1'b0, 1'b0));
    apb(1'b1, {24'h0, OFS_OPA}, 32'h99, r, e);
    chk({31'h0, e}, 32'h1);
    idle();
    rchk(OFS_OPA, 32'h11);
    rchk(OFS_IP, {16'h0, 8'h04, VEC_BP});
    go(cw(4'hf, 1'b0, 1'b0));
    rchk(OFS_STATUS, {16'h0, VEC_BP, 8'h06});
    wr(OFS_STATUS, 32'h4);
    rchk(OFS_STATUS, {16'h0, VEC_BP, 8'h02});
    apb(1'b0, 32'h0000_0030, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, 32'h0000_0104, 32'h5, r, e);
    chk({31'h0, e}, 32'h1);
    rchk(OFS_OPA, 32'h11);
    apb(1'b0, 32'h0000_0104, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("test refuse done");
  endtask

  task automatic enter(input logic [31:0] s, input logic [31:0] l);
    wr(OFS_OPA, s); wr(OFS_OPB, l);
    go(cw(OP_ENTER, 1'b0, 1'b0));
  endtask

  task automatic t_enter();
    wr(OFS_SP, 32'h900); wr(OFS_FBP, 32'habc0);
    enter(32'h8, 32'h0);
    rchk(OFS_FBP, 32'h8fc);
    rchk(OFS_SP, 32'h8f4);
    mchk(32'h8fc, 32'habc0);
    enter(32'h10, 32'h21);
    rchk(OFS_FBP, 32'h8f0);
    rchk(OFS_SP, 32'h8dc);
    mchk(32'h8f0, 32'h8fc);
    mchk(32'h8ec, 32'h8f0);
    enter(32'h4, 32'h2);
    rchk(OFS_FBP, 32'h8d8);
    rchk(OFS_SP, 32'h8cc);
    mchk(32'h8d4, 32'h8f0);
    mchk(32'h8d0, 32'h8d8);
    enter(32'h0, 32'h2);
    rchk(OFS_SP, 32'h8c0);
    mchk(32'h8c4, 32'h8f0);
    mchk(32'h8c0, 32'h8c8);
    go(cw(OP_LEAVE, 1'b0, 1'b0));
    rchk(OFS_SP, 32'h8cc);
    rchk(OFS_FBP, 32'h8d8);
    $display("test enter done");
  endtask

  task automatic t_segq();
    wr(OFS_SEGQ, {29'h0, BASE_FBP});
    rchk(OFS_SEGQ, {28'h0, 1'b1, BASE_FBP});
    wr(OFS_SEGQ, {29'h0, BASE_SP});
    rchk(OFS_SEGQ, {28'h0, 1'b1, BASE_SP});
    wr(OFS_SEGQ, 32'h3);
    rchk(OFS_SEGQ, 32'h3);
    $display("test segq done");
  endtask

  // mid-run reset brings back the reset register values
  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_FLAGS, FLAGS_RST);
    rchk(OFS_SP, SP_RST);
    rchk(OFS_FBP, 32'h0);
    rchk(OFS_STATUS, 32'h0);
    $display("test reset done");
  endtask

  // ****************************************
  // verdict, watchdog, main sequence
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // cuts a hang well past the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    summarize();
  end

  initial begin
    err_count = 0;
    total_checks = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_traps();
    t_interrupt_return_instruction();
    t_refuse();
    t_enter();
    t_segq();
    t_reset();
    summarize();
  end
endmodule // stf_unit_tb
